// >>> hdl/rhd_descriptor_a.sv
// root hub first descriptor register and the port power / overcurrent policy it steers
// assumes single-cycle command strobes from the host register interface on CLK
// What this block does
// - settle time byte, bits 31:24, resets 0xFF
// - overcurrent-absent set means no overcurrent reporting
// - overcurrent mode honoured only when absent clear
// - mode 0 collective, 1 per port
// - overcurrent mode resets like power mode, 1
// - compound device flag read-only zero
// - power always-on 0 switched, 1 always powered
// - power mode honoured only when always-on clear
// - power mode 0 switches ports together
// - power mode 1: mask picks per-port or global
// - port count read-only, value two
// - accessible in every host controller state
// - whole 32-bit word accesses only
`timescale 1ns/1ps
module rhd_descriptor_a
(
    CLK,
    RESET_N,
    CMD_VALID,
    CMD_CODE,
    WR_DATA,
    RD_DATA,
    RD_VALID,
    PORT_POWER_MASK,
    PWR_CMD,
    PORT_OC_IN,
    PORT_POWER,
    OC_MODE,
    PWR_MODE,
    OC_GLOBAL,
    OC_PORT
);
    import rhd_pkg::*;
    input  wire logic                           CLK;
    input  wire logic                           RESET_N;
    input  wire logic                           CMD_VALID;
    input  wire logic [7:0]                     CMD_CODE;
    input  wire logic [31:0]                    WR_DATA;
    output logic      [31:0]                    RD_DATA;
    output logic                                RD_VALID;
    input  wire logic [rhd_pkg::RHD_NPORTS-1:0] PORT_POWER_MASK;
    input  wire rhd_pkg::rhd_pwr_cmd_type       PWR_CMD;
    input  wire logic [rhd_pkg::RHD_NPORTS-1:0] PORT_OC_IN;
    output logic      [rhd_pkg::RHD_NPORTS-1:0] PORT_POWER;
    output rhd_pkg::rhd_oc_mode_type            OC_MODE;
    output rhd_pkg::rhd_pwr_mode_type           PWR_MODE;
    output logic                                OC_GLOBAL;
    output logic      [rhd_pkg::RHD_NPORTS-1:0] OC_PORT;

    rhd_fields_type                fields_q;
    rhd_fields_type                fields_d;
    logic [31:0]                   rd_data_q;
    logic [31:0]                   rd_data_d;
    logic                          rd_valid_q;
    logic                          rd_valid_d;
    logic [RHD_NPORTS-1:0]         power_q;
    logic [RHD_NPORTS-1:0]         power_d;
    rhd_oc_mode_type               oc_mode_q;
    rhd_oc_mode_type               oc_mode_d;
    rhd_pwr_mode_type              pwr_mode_q;
    rhd_pwr_mode_type              pwr_mode_d;
    logic                          oc_global_q;
    logic                          oc_global_d;
    logic [RHD_NPORTS-1:0]         oc_port_q;
    logic [RHD_NPORTS-1:0]         oc_port_d;
    // first stage may go metastable; only the second stage feeds logic
    logic [RHD_NPORTS-1:0]         oc_meta_q;
    logic [RHD_NPORTS-1:0]         oc_sync_q;
    logic [31:0]                   image;

    // the settle time is only held for software to read back; no timer runs from it,
    // so the wait before touching a newly powered port is the driver's job
    // register image as seen by a read; no state gating, so any controller state works
    always_comb
    begin
        image = 32'h0000_0000;
        image[RHD_SETTLE_MSB:RHD_SETTLE_LSB] = fields_q.settle_time;
        image[RHD_OC_ABSENT]   = fields_q.oc_absent;
        image[RHD_OC_PER_PORT] = fields_q.oc_per_port;
        image[RHD_COMPOUND]    = RHD_COMPOUND_VALUE;
        image[RHD_PWR_ALWAYS]  = fields_q.pwr_always_on;
        image[RHD_PWR_PER_PRT] = fields_q.pwr_per_port;
        image[RHD_PORTS_MSB:RHD_PORTS_LSB] = RHD_PORT_COUNT;
    end

    // command decode: one full word per access, only writable fields taken
    always_comb
    begin
        fields_d   = fields_q;
        rd_data_d  = rd_data_q;
        rd_valid_d = 1'b0;
        // one code per strobe, so a read and a write never meet in one cycle
        if (CMD_VALID && CMD_CODE == RHD_CMD_WRITE)
        begin
            fields_d.settle_time   = WR_DATA[RHD_SETTLE_MSB:RHD_SETTLE_LSB];
            fields_d.oc_absent     = WR_DATA[RHD_OC_ABSENT];
            fields_d.oc_per_port   = WR_DATA[RHD_OC_PER_PORT];
            fields_d.pwr_always_on = WR_DATA[RHD_PWR_ALWAYS];
            fields_d.pwr_per_port  = WR_DATA[RHD_PWR_PER_PRT];
        end
        else if (CMD_VALID && CMD_CODE == RHD_CMD_READ)
        begin
            rd_data_d  = image;
            rd_valid_d = 1'b1;
        end
    end

    // effective modes decoded from the fields
    always_comb
    begin
        if (fields_q.oc_absent)
            oc_mode_d = RHD_OC_NONE;
        else if (fields_q.oc_per_port)
            oc_mode_d = RHD_OC_INDIVIDUAL;
        else
            oc_mode_d = RHD_OC_COLLECTIVE;
        // always-on outranks the switching mode bit
        if (fields_q.pwr_always_on)
            pwr_mode_d = RHD_PWR_ALWAYS_ON;
        else if (fields_q.pwr_per_port)
            pwr_mode_d = RHD_PWR_PER_PORT;
        else
            pwr_mode_d = RHD_PWR_GANGED;
    end

    // port power and overcurrent reporting, one slice per port
    genvar gi;
    generate
        for (gi = 0; gi < RHD_NPORTS; gi++)
        begin : g_port
            logic use_port_cmd;
            always_comb
            begin
                use_port_cmd = 1'b0;
                power_d[gi]  = power_q[gi];
                case (pwr_mode_q)
                    RHD_PWR_ALWAYS_ON:
                        power_d[gi] = 1'b1;
                    RHD_PWR_GANGED:
                    begin
                        // all ports follow the global command together
                        if (PWR_CMD.global_set)
                            power_d[gi] = 1'b1;
                        else if (PWR_CMD.global_clear)
                            power_d[gi] = 1'b0;
                    end
                    RHD_PWR_PER_PORT:
                    begin
                        // a masked port hears only its own command, set beating clear
                        use_port_cmd = PORT_POWER_MASK[gi];
                        if (use_port_cmd && PWR_CMD.port_set[gi])
                            power_d[gi] = 1'b1;
                        else if (use_port_cmd && PWR_CMD.port_clear[gi])
                            power_d[gi] = 1'b0;
                        else if (!use_port_cmd && PWR_CMD.global_set)
                            power_d[gi] = 1'b1;
                        else if (!use_port_cmd && PWR_CMD.global_clear)
                            power_d[gi] = 1'b0;
                    end
                    default:
                        power_d[gi] = power_q[gi];
                endcase
                // per-port report stays quiet outside individual mode
                oc_port_d[gi] = (oc_mode_q == RHD_OC_INDIVIDUAL) && oc_sync_q[gi];
            end
        end
    endgenerate

    // collective report ors all ports; silent when reporting absent
    always_comb
    begin
        oc_global_d = (oc_mode_q == RHD_OC_COLLECTIVE) && (|oc_sync_q);
    end

    // registers; overcurrent pins are asynchronous so they go through two stages
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            fields_q.settle_time   <= RHD_SETTLE_RESET;
            fields_q.oc_absent     <= RHD_OC_ABSENT_RESET;
            fields_q.oc_per_port   <= RHD_OC_PORT_RESET;
            fields_q.pwr_always_on <= RHD_PWR_ALWAYS_RESET;
            fields_q.pwr_per_port  <= RHD_PWR_PORT_RESET;
            rd_data_q              <= 32'h0000_0000;
            rd_valid_q             <= 1'b0;
            power_q                <= '0;
            oc_mode_q              <= RHD_OC_INDIVIDUAL;
            pwr_mode_q             <= RHD_PWR_PER_PORT;
            oc_global_q            <= 1'b0;
            oc_port_q              <= '0;
            oc_meta_q              <= '0;
            oc_sync_q              <= '0;
        end
        else
        begin
            fields_q    <= fields_d;
            rd_data_q   <= rd_data_d;
            rd_valid_q  <= rd_valid_d;
            power_q     <= power_d;
            oc_mode_q   <= oc_mode_d;
            pwr_mode_q  <= pwr_mode_d;
            oc_global_q <= oc_global_d;
            oc_port_q   <= oc_port_d;
            oc_meta_q   <= PORT_OC_IN;
            oc_sync_q   <= oc_meta_q;
        end
    end

    // every output straight from its register, so no decode glitch reaches a pin
    assign RD_DATA   = rd_data_q;
    assign RD_VALID  = rd_valid_q;
    assign PORT_POWER = power_q;
    assign OC_MODE   = oc_mode_q;
    assign PWR_MODE  = pwr_mode_q;
    assign OC_GLOBAL = oc_global_q;
    assign OC_PORT   = oc_port_q;
endmodule

// >>> hdl/rhd_pkg.sv
// package for the root hub first descriptor register block
// assumes a 32-bit host register port addressed by read/write command codes
package rhd_pkg;
    // command codes: read and write of this register
    localparam logic [7:0] RHD_CMD_READ  = 8'h12;
    localparam logic [7:0] RHD_CMD_WRITE = 8'h92;

    // field positions
    localparam int RHD_SETTLE_LSB  = 24;
    localparam int RHD_SETTLE_MSB  = 31;
    localparam int RHD_OC_ABSENT   = 12;
    localparam int RHD_OC_PER_PORT = 11;
    localparam int RHD_COMPOUND    = 10;
    localparam int RHD_PWR_ALWAYS  = 9;
    localparam int RHD_PWR_PER_PRT = 8;
    localparam int RHD_PORTS_MSB   = 1;
    localparam int RHD_PORTS_LSB   = 0;

    // reset and fixed values
    localparam logic [7:0] RHD_SETTLE_RESET     = 8'hFF;
    localparam logic       RHD_OC_ABSENT_RESET  = 1'b0;
    localparam logic       RHD_OC_PORT_RESET    = 1'b1;
    localparam logic       RHD_PWR_ALWAYS_RESET = 1'b0;
    localparam logic       RHD_PWR_PORT_RESET   = 1'b1;
    localparam logic       RHD_COMPOUND_VALUE   = 1'b0;
    localparam logic [1:0] RHD_PORT_COUNT       = 2'h2;
    localparam int         RHD_NPORTS           = 2;

    // settle time unit
    localparam int RHD_SETTLE_UNIT_MS = 2;

    // overcurrent reporting modes
    typedef enum logic [1:0]
    {
        RHD_OC_NONE       = 2'b00,
        RHD_OC_COLLECTIVE = 2'b01,
        RHD_OC_INDIVIDUAL = 2'b10
    } rhd_oc_mode_type;

    // power switching modes
    typedef enum logic [1:0]
    {
        RHD_PWR_ALWAYS_ON = 2'b00,
        RHD_PWR_GANGED    = 2'b01,
        RHD_PWR_PER_PORT  = 2'b10
    } rhd_pwr_mode_type;

    // register fields held in flip-flops
    typedef struct packed
    {
        logic [7:0] settle_time;
        logic       oc_absent;
        logic       oc_per_port;
        logic       pwr_always_on;
        logic       pwr_per_port;
    } rhd_fields_type;

    // power commands from the hub logic
    typedef struct packed
    {
        logic                  global_set;
        logic                  global_clear;
        logic [RHD_NPORTS-1:0] port_set;
        logic [RHD_NPORTS-1:0] port_clear;
    } rhd_pwr_cmd_type;
endpackage

// >>> verification/rhd_desc_asserts.sv
// checker for the root hub first descriptor register
// assumes a bind onto rhd_descriptor_a, ports watched as they are
`timescale 1ns/1ps
module rhd_desc_asserts
import rhd_pkg::*;
(
    input wire logic             CLK,
    input wire logic             RESET_N,
    input wire logic             CMD_VALID,
    input wire logic [7:0]       CMD_CODE,
    input wire logic [31:0]      WR_DATA,
    input wire logic [31:0]      RD_DATA,
    input wire logic             RD_VALID,
    input wire logic [1:0]       PORT_POWER_MASK,
    input wire rhd_pwr_cmd_type  PWR_CMD,
    input wire logic [1:0]       PORT_POWER,
    input wire rhd_oc_mode_type  OC_MODE,
    input wire rhd_pwr_mode_type PWR_MODE,
    input wire logic             OC_GLOBAL,
    input wire logic [1:0]       OC_PORT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // first steps of a mode change: the write that sets the controlling bit
    sequence wr_oc_off;
        CMD_VALID && CMD_CODE == RHD_CMD_WRITE && WR_DATA[RHD_OC_ABSENT];
    endsequence
    sequence wr_pwr_on;
        CMD_VALID && CMD_CODE == RHD_CMD_WRITE && WR_DATA[RHD_PWR_ALWAYS];
    endsequence
    AST_RD_ANSWER: assert property (CMD_VALID && CMD_CODE == RHD_CMD_READ |=> RD_VALID)
        else $error("read not answered");
    AST_FIXED: assert property (RD_VALID |-> !RD_DATA[10] && RD_DATA[1:0] == 2'h2)
        else $error("fixed field wrong");
    AST_RSVD: assert property
        (RD_VALID |-> RD_DATA[23:13] == 11'h000 && RD_DATA[7:2] == 6'h00)
        else $error("reserved bits not zero");
    AST_OC_NONE: assert property (wr_oc_off |-> ##2 OC_MODE == RHD_OC_NONE)
        else $error("overcurrent still reported");
    AST_ALWAYS_ON: assert property
        (wr_pwr_on |-> ##2 PWR_MODE == RHD_PWR_ALWAYS_ON ##1 PORT_POWER == 2'h3)
        else $error("ports not always powered");
    // one cycle of lag allowed while the mode register itself moves
    AST_OC_GLOBAL: assert property
        (OC_GLOBAL |-> OC_MODE == RHD_OC_COLLECTIVE || $past(OC_MODE) == RHD_OC_COLLECTIVE)
        else $error("collective flag outside its mode");
    AST_OC_PORT: assert property
        (OC_PORT != 2'h0 |-> OC_MODE == RHD_OC_INDIVIDUAL
            || $past(OC_MODE) == RHD_OC_INDIVIDUAL)
        else $error("per-port flag outside its mode");
    AST_GANGED: assert property
        (PWR_MODE == RHD_PWR_GANGED && PWR_CMD.global_set |=> PORT_POWER == 2'h3)
        else $error("ganged ports not powered together");
    AST_PER_PORT: assert property
        (PWR_MODE == RHD_PWR_PER_PORT && PWR_CMD == 6'h1C
            |=> PORT_POWER == $past(PORT_POWER_MASK))
        else $error("mask not honoured");
endmodule

// >>> verification/rhd_descriptor_a_bench.sv
// self-checking bench for the root hub first descriptor register
// drives every port itself; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module rhd_descriptor_a_bench;
    import rhd_pkg::*;
    typedef struct packed
    {
        logic [31:0] w;
        logic [1:0]  m;
        logic [5:0]  c;
        logic [1:0]  e;
    } rhd_step_type;
    logic             CLK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, OC_GLOBAL, RD_VALID;
    logic [7:0]       CMD_CODE = 8'h00;
    logic [31:0]      WR_DATA = 32'h0, RD_DATA, w;
    logic [1:0]       PORT_POWER_MASK = 2'h0, PORT_OC_IN = 2'h0, PORT_POWER, OC_PORT;
    rhd_pwr_cmd_type  PWR_CMD = '0;
    rhd_oc_mode_type  OC_MODE;
    rhd_pwr_mode_type PWR_MODE;
    int               failures = 0, tests_run = 0;
    // ganged ignores port commands; always-on must beat every clear
    rhd_step_type     steps [8] = '{'{32'h0, 2'h0, 6'h20, 2'h3}, '{32'h0, 2'h0, 6'h10, 2'h0},
        '{32'h0, 2'h3, 6'h0C, 2'h0}, '{32'h100, 2'h1, 6'h1C, 2'h1}, '{32'h100, 2'h1, 6'h20, 2'h3},
        '{32'h100, 2'h1, 6'h03, 2'h2}, '{32'h200, 2'h0, 6'h10, 2'h3}, '{32'h300, 2'h0, 6'h13, 2'h3}};
    logic [31:0]      oc_w [3] = '{32'h0, 32'h800, 32'h1000};
    logic [2:0]       oc_e [3] = '{3'b100, 3'b010, 3'b000};
    rhd_descriptor_a u_rhd_descriptor_a (.CLK, .RESET_N, .CMD_VALID, .CMD_CODE, .WR_DATA,
        .RD_DATA, .RD_VALID, .PORT_POWER_MASK, .PWR_CMD, .PORT_OC_IN, .PORT_POWER, .OC_MODE,
        .PWR_MODE, .OC_GLOBAL, .OC_PORT);
    always #12.5 CLK = ~CLK;
    function automatic rhd_oc_mode_type oc_exp(input logic [31:0] v);
        return v[12] ? RHD_OC_NONE : (v[11] ? RHD_OC_INDIVIDUAL : RHD_OC_COLLECTIVE);
    endfunction
    function automatic rhd_pwr_mode_type pw_exp(input logic [31:0] v);
        return v[9] ? RHD_PWR_ALWAYS_ON : (v[8] ? RHD_PWR_PER_PORT : RHD_PWR_GANGED);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobe stays high on return so commands can run back to back
    task automatic cmd(input logic [7:0] code, input logic [31:0] data);
        CMD_CODE = code;
        WR_DATA = data;
        CMD_VALID = 1'b1;
        @(posedge CLK);
        #1;
    endtask
    task automatic rd(input logic [31:0] exp);
        cmd(RHD_CMD_READ, $urandom);
        CMD_VALID = 1'b0;
        chk({31'h0, RD_VALID}, 32'h1);
        chk(RD_DATA, exp);
        @(posedge CLK);
        #1;
        chk({31'h0, RD_VALID}, 32'h0);
    endtask
    task automatic rst();
        RESET_N = 1'b0;
        repeat (10) @(posedge CLK);
        #1 RESET_N = 1'b1;
        rd(32'hFF000902);
        chk({28'h0, OC_MODE, PWR_MODE}, 32'hA);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        void'($urandom(79869));
        #1 rst();
        // power-up habit: overcurrent mode cleared, then set for per-port reporting
        cmd(RHD_CMD_WRITE, 32'hFF000100);
        rd(32'hFF000102);
        chk(32'(OC_MODE), 32'(RHD_OC_COLLECTIVE));
        cmd(RHD_CMD_WRITE, 32'hFF000900);
        rd(32'hFF000902);
        chk(32'(OC_MODE), 32'(RHD_OC_INDIVIDUAL));
        // corners first, then random words; an alien code in between must be ignored
        for (int i = 0; i < 24; i++)
        begin
            w = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h0 : $urandom);
            cmd(RHD_CMD_WRITE, w);
            cmd(8'h13, ~w);
            rd((w & 32'hFF001B00) | 32'h2);
            chk(32'(OC_MODE), 32'(oc_exp(w)));
            chk(32'(PWR_MODE), 32'(pw_exp(w)));
            if (w[9]) chk(32'(PORT_POWER), 32'h3);
        end
        foreach (steps[k])
        begin
            PORT_POWER_MASK = steps[k].m;
            cmd(RHD_CMD_WRITE, steps[k].w);
            rd((steps[k].w & 32'hFF001B00) | 32'h2);
            PWR_CMD = steps[k].c;
            @(posedge CLK);
            #1 PWR_CMD = '0;
            chk(32'(PORT_POWER), 32'(steps[k].e));
        end
        PORT_OC_IN = 2'h2;
        foreach (oc_w[k])
        begin
            cmd(RHD_CMD_WRITE, oc_w[k]);
            rd((oc_w[k] & 32'hFF001B00) | 32'h2);
            repeat (3) @(posedge CLK);
            #1 chk({29'h0, OC_GLOBAL, OC_PORT}, {29'h0, oc_e[k]});
        end
        rst();
        chk(32'(PORT_POWER), 32'h0);
        conclude();
    end
endmodule
bind rhd_descriptor_a rhd_desc_asserts u_rhd_desc_asserts (.CLK(CLK), .RESET_N(RESET_N),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .PORT_POWER_MASK(PORT_POWER_MASK), .PWR_CMD(PWR_CMD),
    .PORT_POWER(PORT_POWER), .OC_MODE(OC_MODE), .PWR_MODE(PWR_MODE), .OC_GLOBAL(OC_GLOBAL),
    .OC_PORT(OC_PORT));
